/* File: rtl/oag_pkg.sv */
// Package: operand address generator constants and enumerations
// Assumes the core clock domain only; no software-visible registers
`default_nettype none
package oag_pkg;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} opsize_t;
   typedef enum logic [3:0] {
      AM_IND, AM_POSTINC, AM_PREDEC, AM_DISP4, AM_DISP12, AM_IDX,
      AM_GBR_DISP, AM_GBR_IDX, AM_TBR_DBL, AM_PC_DISP, AM_BR8, AM_BR12,
      AM_BR_REG, AM_NONE
   } amode_t;
   typedef enum logic [2:0] {
      IM_NONE, IM_IMM20, IM_IMM20S, IM_ZX8, IM_SX8, IM_TRAP, IM_BIT3
   } imode_t;
   localparam int XLEN          = 32;
   localparam int DISP4_LSB     = 0;
   localparam int DISP4_W       = 4;
   localparam int DISP8_W       = 8;
   localparam int DISP12_W      = 12;
   localparam int IMM20_W       = 20;
   localparam int IMM20S_SHIFT  = 8;
   localparam int FLD_HI_LSB    = 8;
   localparam int FLD_MID_LSB   = 4;
   localparam int BITNO_W       = 3;
   localparam int BITOP_BIT     = 3;
   localparam logic [31:0] PC_LONG_MASK = 32'hffff_fffc;
   localparam logic [31:0] ZERO32       = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: rtl/oag_field_decode.sv */
// Field decoder: splits instruction halfwords into register and immediate fields
// Assumes the halfwords are stable in the cycle they are presented
`default_nettype none
module oag_field_decode (
   input  wire logic [15:0] hw0,
   input  wire logic [15:0] hw1,
   output logic      [3:0]  dest_gpr,
   output logic      [3:0]  src_gpr,
   output logic      [3:0]  disp4,
   output logic      [7:0]  disp8,
   output logic      [11:0] disp12,
   output logic      [19:0] imm20,
   output logic      [2:0]  bit_no,
   output logic             bit_op_sel
);
   // Register fields at 11:8 and 7:4
   assign dest_gpr   = hw0[oag_pkg::FLD_HI_LSB +: 4];   // [RL21] [RL19]
   assign src_gpr    = hw0[oag_pkg::FLD_MID_LSB +: 4];  // [RL20] [RL22]
   assign disp4      = hw0[oag_pkg::DISP4_LSB +: oag_pkg::DISP4_W]; // [RL20]
   assign disp8      = hw0[7:0];                        // [RL21]
   assign disp12     = hw0[11:0];
   assign imm20      = {hw0[7:4], hw1};                 // [RL23]
   assign bit_no     = hw0[oag_pkg::BITNO_W-1:0];       // [RL22] [RL18]
   assign bit_op_sel = hw0[oag_pkg::BITOP_BIT];         // [RL22]
endmodule
`default_nettype wire

/* File: rtl/operand_address_generator.sv */
// Operand address generator: effective addresses, base write-back, immediates
// Assumes register file values and memory read data are on the core clock
`default_nettype none
// What this block does
// RL1 - Post-increment: address is base, then base grows by 1, 2 or 4
// RL2 - Predecrement: base shrinks by 1, 2 or 4, shrunk value is address
// RL3 - Short displacement zero-extended, scaled by size, added to base
// RL4 - Long 12-bit displacement zero-extended, added unscaled to base
// RL5 - Indexed: address is named register plus register zero
// RL6 - Global base plus zero-extended 8-bit displacement scaled by size
// RL7 - Indexed global base: global base plus register zero
// RL8 - Table base plus displacement times four, memory word is address
// RL9 - PC operand: displacement doubled for word, longword masks PC low bits
// RL10 - 8-bit branch displacement sign-extended, doubled, added to PC
// RL11 - 12-bit branch displacement sign-extended, doubled, added to PC
// RL12 - Register branch target is PC plus named register
// RL13 - Plain 20-bit immediate load is sign-extended to 32 bits
// RL14 - Shifted 20-bit immediate sits at 27:8, low byte zero, sign above
// RL15 - Logic-class 8-bit immediates are zero-extended
// RL16 - Move, add, compare-equal 8-bit immediates are sign-extended
// RL17 - Trap immediate zero-extended and times four gives vector offset
// RL18 - 3-bit immediate of bit instructions names the target bit
// RL19 - Multiply-accumulate field 11:8 is a second source address
// RL20 - Displacement load: base at 7:4, displacement at 3:0
// RL21 - PC load: destination at 11:8, displacement at 7:0
// RL22 - Bit format: register 7:4, opcode bit 3, bit number 2:0
// RL23 - 32-bit immediate: register 11:8, imm bits from 7:4 plus halfword two
// RL24 - Misaligned word or longword address raises an address error, except in branch and table double-indirect modes
// RL25 - All address arithmetic is 32-bit, carries dropped
module operand_address_generator (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  req_valid,
   input  wire oag_pkg::amode_t       amode,
   input  wire oag_pkg::imode_t       imode,
   input  wire oag_pkg::opsize_t      opsize,
   input  wire logic                  mac_op,
   input  wire logic [15:0]           insn_hw0,
   input  wire logic [15:0]           insn_hw1,
   input  wire logic [31:0]           base_val,
   input  wire logic [31:0]           gpr_zero,
   input  wire logic [31:0]           global_base_reg,
   input  wire logic [31:0]           table_base_reg,
   input  wire logic [31:0]           pc_val,
   input  wire logic                  mem_rd_valid,
   input  wire logic [31:0]           mem_rd_data,
   output logic                       busy,
   output logic                       ea_valid,
   output logic [31:0]                ea,
   output logic                       addr_error,
   output logic                       wb_valid,
   output logic [3:0]                 wb_reg,
   output logic [31:0]                wb_data,
   output logic                       tbl_rd_req,
   output logic [31:0]                tbl_rd_addr,
   output logic                       imm_valid,
   output logic [31:0]                imm_out,
   output logic [3:0]                 dest_gpr,
   output logic [3:0]                 src_gpr,
   output logic                       src2_is_dest,
   output logic [2:0]                 bit_no,
   output logic                       bit_op_sel
);
   typedef enum logic [1:0] {ST_IDLE, ST_TBL_REQ, ST_TBL_WAIT} state_t;

   state_t      state;
   logic [3:0]  disp4;
   logic [7:0]  disp8;
   logic [11:0] disp12;
   logic [11:0] disp12_long;
   logic [19:0] imm20;
   logic [31:0] next_ea;
   logic [31:0] next_wb;
   logic        next_wb_en;
   logic [31:0] next_imm;
   logic [31:0] tbl_addr;
   logic [31:0] step;

   oag_field_decode u_fields (
      .hw0        (insn_hw0),
      .hw1        (insn_hw1),
      .dest_gpr   (dest_gpr),
      .src_gpr    (src_gpr),
      .disp4      (disp4),
      .disp8      (disp8),
      .disp12     (disp12),
      .imm20      (imm20),
      .bit_no     (bit_no),
      .bit_op_sel (bit_op_sel)
   );

   // Scale a zero-extended displacement by operand size
   function automatic logic [31:0] scale(input logic [31:0] d, input oag_pkg::opsize_t sz);
      case (sz)
         oag_pkg::SZ_WORD: scale = {d[30:0], 1'b0};
         oag_pkg::SZ_LONG: scale = {d[29:0], 2'b00};
         default:          scale = d;
      endcase
   endfunction

   // Alignment check for an operand address
   function automatic logic misaligned(input logic [31:0] a, input oag_pkg::opsize_t sz);
      case (sz)
         oag_pkg::SZ_WORD: misaligned = a[0];
         oag_pkg::SZ_LONG: misaligned = |a[1:0];
         default:          misaligned = 1'b0;
      endcase
   endfunction

   assign step         = scale(32'h0000_0001, opsize);                   // [RL1] [RL2]
   assign src2_is_dest = mac_op;                                         // [RL19]
   assign tbl_addr     = table_base_reg + {22'h0, disp8, 2'b00};         // [RL8] [RL25]
   assign busy         = (state != ST_IDLE);
   // Long displacement sits in the second halfword
   assign disp12_long  = insn_hw1[11:0];                                 // [RL4]

   // Effective address and write-back value
   always_comb begin
      next_ea    = oag_pkg::ZERO32;
      next_wb    = base_val;
      next_wb_en = 1'b0;
      case (amode)
         oag_pkg::AM_IND: next_ea = base_val;
         oag_pkg::AM_POSTINC: begin
            next_ea    = base_val;                                       // [RL1]
            next_wb    = base_val + step;                                // [RL1] [RL25]
            next_wb_en = 1'b1;
         end
         oag_pkg::AM_PREDEC: begin
            next_wb    = base_val - step;                                // [RL2] [RL25]
            next_ea    = next_wb;                                        // [RL2]
            next_wb_en = 1'b1;
         end
         oag_pkg::AM_DISP4:
            next_ea = base_val + scale({28'h0000000, disp4}, opsize);    // [RL3]
         oag_pkg::AM_DISP12:
            next_ea = base_val + {20'h00000, disp12_long};               // [RL4]
         oag_pkg::AM_IDX:
            next_ea = base_val + gpr_zero;                               // [RL5]
         oag_pkg::AM_GBR_DISP:
            next_ea = global_base_reg + scale({24'h000000, disp8}, opsize); // [RL6]
         oag_pkg::AM_GBR_IDX:
            next_ea = global_base_reg + gpr_zero;                        // [RL7]
         oag_pkg::AM_PC_DISP: begin
            if (opsize == oag_pkg::SZ_LONG) begin
               next_ea = (pc_val & oag_pkg::PC_LONG_MASK)
                       + {22'h0, disp8, 2'b00};                          // [RL9]
            end else begin
               next_ea = pc_val + {23'h0, disp8, 1'b0};                  // [RL9]
            end
         end
         oag_pkg::AM_BR8:
            next_ea = pc_val + {{23{disp8[7]}}, disp8, 1'b0};            // [RL10]
         oag_pkg::AM_BR12:
            next_ea = pc_val + {{19{disp12[11]}}, disp12, 1'b0};         // [RL11]
         oag_pkg::AM_BR_REG:
            next_ea = pc_val + base_val;                                 // [RL12]
         default: next_ea = oag_pkg::ZERO32;
      endcase
   end

   // Immediate extension
   always_comb begin
      case (imode)
         oag_pkg::IM_IMM20:
            next_imm = {{12{imm20[19]}}, imm20};                         // [RL13]
         oag_pkg::IM_IMM20S:
            next_imm = {{4{imm20[19]}}, imm20, 8'h00};                   // [RL14]
         oag_pkg::IM_ZX8:  next_imm = {24'h000000, disp8};               // [RL15]
         oag_pkg::IM_SX8:  next_imm = {{24{disp8[7]}}, disp8};           // [RL16]
         oag_pkg::IM_TRAP: next_imm = {22'h0, disp8, 2'b00};             // [RL17]
         oag_pkg::IM_BIT3: next_imm = {29'h0, bit_no};                   // [RL18]
         default:          next_imm = oag_pkg::ZERO32;
      endcase
   end

   // Table double-indirect sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE:
               if (req_valid && amode == oag_pkg::AM_TBR_DBL) begin
                  state <= ST_TBL_REQ;
               end
            ST_TBL_REQ: state <= ST_TBL_WAIT;
            ST_TBL_WAIT:
               if (mem_rd_valid) begin
                  state <= ST_IDLE;
               end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Table read request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tbl_rd_req  <= 1'b0;
         tbl_rd_addr <= oag_pkg::ZERO32;
      end else begin
         tbl_rd_req <= (state == ST_IDLE) && req_valid && amode == oag_pkg::AM_TBR_DBL;
         if (state == ST_IDLE && req_valid) begin
            tbl_rd_addr <= tbl_addr;                                     // [RL8]
         end
      end
   end

   // Effective address result and alignment error
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ea_valid   <= 1'b0;
         ea         <= oag_pkg::ZERO32;
         addr_error <= 1'b0;
      end else begin
         ea_valid   <= 1'b0;
         addr_error <= 1'b0;
         if (state == ST_TBL_WAIT && mem_rd_valid) begin
            ea_valid <= 1'b1;
            ea       <= mem_rd_data;                                     // [RL8]
         end else if (state == ST_IDLE && req_valid && amode != oag_pkg::AM_TBR_DBL
                      && amode != oag_pkg::AM_NONE) begin
            ea_valid   <= 1'b1;
            ea         <= next_ea;
            addr_error <= misaligned(next_ea, opsize)
                          && amode != oag_pkg::AM_BR8 && amode != oag_pkg::AM_BR12
                          && amode != oag_pkg::AM_BR_REG;                // [RL24]
         end
      end
   end

   // Base register write-back
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_valid <= 1'b0;
         wb_reg   <= 4'h0;
         wb_data  <= oag_pkg::ZERO32;
      end else begin
         wb_valid <= (state == ST_IDLE) && req_valid && next_wb_en;      // [RL1] [RL2]
         if (state == ST_IDLE && req_valid && next_wb_en) begin
            wb_reg  <= src_gpr;
            wb_data <= next_wb;
         end
      end
   end

   // Immediate result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         imm_valid <= 1'b0;
         imm_out   <= oag_pkg::ZERO32;
      end else begin
         imm_valid <= (state == ST_IDLE) && req_valid && imode != oag_pkg::IM_NONE;
         if (state == ST_IDLE && req_valid) begin
            imm_out <= next_imm;
         end
      end
   end

   property p_postinc;
      @(posedge clk) disable iff (!rst_n)
      (state == ST_IDLE && req_valid && amode == oag_pkg::AM_POSTINC)
      |=> wb_valid && wb_data == $past(base_val) + $past(step) && ea == $past(base_val);
   endproperty
   a_postinc: assert property (p_postinc) else $error("post-increment wrong"); // [RL1]

   property p_predec;
      @(posedge clk) disable iff (!rst_n)
      (state == ST_IDLE && req_valid && amode == oag_pkg::AM_PREDEC)
      |=> wb_valid && ea == wb_data && wb_data == $past(base_val) - $past(step);
   endproperty
   a_predec: assert property (p_predec) else $error("predecrement wrong"); // [RL2]

   property p_disp12;
      @(posedge clk) disable iff (!rst_n)
      (state == ST_IDLE && req_valid && amode == oag_pkg::AM_DISP12)
      |=> ea_valid && ea == $past(base_val) + {20'h00000, $past(insn_hw1[11:0])};
   endproperty
   a_disp12: assert property (p_disp12) else $error("disp12 address wrong"); // [RL4]

   property p_idx;
      @(posedge clk) disable iff (!rst_n)
      (state == ST_IDLE && req_valid && amode == oag_pkg::AM_IDX)
      |=> ea_valid && ea == $past(base_val) + $past(gpr_zero);
   endproperty
   a_idx: assert property (p_idx) else $error("indexed address wrong"); // [RL5]

   property p_gbr_idx;
      @(posedge clk) disable iff (!rst_n)
      (state == ST_IDLE && req_valid && amode == oag_pkg::AM_GBR_IDX)
      |=> ea == $past(global_base_reg) + $past(gpr_zero);
   endproperty
   a_gbr_idx: assert property (p_gbr_idx) else $error("gbr index wrong"); // [RL7]

   property p_tbl;
      @(posedge clk) disable iff (!rst_n)
      (state == ST_IDLE && req_valid && amode == oag_pkg::AM_TBR_DBL)
      |=> tbl_rd_req && !ea_valid
          && tbl_rd_addr == $past(table_base_reg) + {22'h0, $past(insn_hw0[7:0]), 2'b00};
   endproperty
   a_tbl: assert property (p_tbl) else $error("table read wrong"); // [RL8]

   property p_imm20;
      @(posedge clk) disable iff (!rst_n)
      (state == ST_IDLE && req_valid && imode == oag_pkg::IM_IMM20)
      |=> imm_valid
          && imm_out == {{12{$past(insn_hw0[7])}}, $past(insn_hw0[7:4]), $past(insn_hw1)};
   endproperty
   a_imm20: assert property (p_imm20) else $error("imm20 extension wrong"); // [RL13]

   property p_align;
      @(posedge clk) disable iff (!rst_n)
      (ea_valid && !addr_error && $past(amode) == oag_pkg::AM_IND && $past(state) == ST_IDLE)
      |-> !($past(opsize) == oag_pkg::SZ_LONG && ea[1:0] != 2'b00);
   endproperty
   a_align: assert property (p_align) else $error("misaligned longword not flagged"); // [RL24]
endmodule
`default_nettype wire

/* File: verification/tbl_mem_model.sv */
// Table read responder in place of the memory access unit
// Assumes one table read outstanding at a time, core clock only
`default_nettype none
module tbl_mem_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        tbl_rd_req,
   input  wire logic [31:0] tbl_rd_addr,
   input  wire logic [3:0]  wait_cycles,
   output logic             mem_rd_valid,
   output logic [31:0]      mem_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        pending;
   logic [3:0]  cnt;
   logic [31:0] addr;
   // Answers after a set delay, data churns while idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         cnt <= 4'h0;
         addr <= 32'h0000_0000;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 32'h0000_0000;
      end else begin
         mem_rd_valid <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
         if (tbl_rd_req) begin
            pending <= 1'b1;
            cnt <= wait_cycles;
            addr <= tbl_rd_addr;
         end else if (pending && cnt == 4'h0) begin
            pending <= 1'b0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= addr ^ 32'ha5a5_0f0f;
         end else if (pending) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/operand_address_generator_bench.sv */
// Testbench for the operand address generator
// Assumes the design package is compiled first
`default_nettype none
module operand_address_generator_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rst_n, req_valid, mac_op, mem_rd_valid;
   oag_pkg::amode_t   amode;
   oag_pkg::imode_t   imode;
   oag_pkg::opsize_t  opsize;
   logic [15:0]       insn_hw0, insn_hw1;
   logic [31:0]       base_val, gpr_zero, global_base_reg, table_base_reg, pc_val;
   logic [31:0]       mem_rd_data, ea, wb_data, tbl_rd_addr, imm_out;
   logic              busy, ea_valid, addr_error, wb_valid, tbl_rd_req, imm_valid;
   logic              src2_is_dest, bit_op_sel;
   logic [3:0]        wb_reg, dest_gpr, src_gpr, wait_cycles;
   logic [2:0]        bit_no;
   int                err_total, checked;

   operand_address_generator u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
      .amode(amode), .imode(imode), .opsize(opsize), .mac_op(mac_op),
      .insn_hw0(insn_hw0), .insn_hw1(insn_hw1), .base_val(base_val), .gpr_zero(gpr_zero),
      .global_base_reg(global_base_reg), .table_base_reg(table_base_reg), .pc_val(pc_val),
      .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .busy(busy),
      .ea_valid(ea_valid), .ea(ea), .addr_error(addr_error), .wb_valid(wb_valid),
      .wb_reg(wb_reg), .wb_data(wb_data), .tbl_rd_req(tbl_rd_req),
      .tbl_rd_addr(tbl_rd_addr), .imm_valid(imm_valid), .imm_out(imm_out),
      .dest_gpr(dest_gpr), .src_gpr(src_gpr), .src2_is_dest(src2_is_dest),
      .bit_no(bit_no), .bit_op_sel(bit_op_sel));
   tbl_mem_model u_mem (.clk(clk), .rst_n(rst_n), .tbl_rd_req(tbl_rd_req),
      .tbl_rd_addr(tbl_rd_addr), .wait_cycles(wait_cycles),
      .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

   always #10 clk = ~clk;

   task stop_test;
      if (err_total == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task req(input oag_pkg::amode_t am, input oag_pkg::imode_t im,
            input oag_pkg::opsize_t sz, input logic [15:0] h0, input logic [15:0] h1,
            input logic [31:0] b);
      @(posedge clk);
      amode <= am;
      imode <= im;
      opsize <= sz;
      insn_hw0 <= h0;
      insn_hw1 <= h1;
      base_val <= b;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
   endtask

   task t_incdec;
      logic [31:0] st;
      for (int s = 0; s < 3; s++) begin
         st = 32'h0000_0001 << s;
         req(oag_pkg::AM_POSTINC, oag_pkg::IM_NONE, oag_pkg::opsize_t'(s), 16'h0050,
             16'h0000, 32'hffff_fffc);
         chk("post ea", 32'hffff_fffc, ea);
         chk("post wb", 32'hffff_fffc + st, wb_data);
         chk("post wb_valid", 32'h1, wb_valid);
         chk("wb_reg", 32'h5, wb_reg);
         req(oag_pkg::AM_PREDEC, oag_pkg::IM_NONE, oag_pkg::opsize_t'(s), 16'h0050,
             16'h0000, 32'h0000_0000);
         chk("pre ea", 32'h0 - st, ea);
         chk("pre wb", 32'h0 - st, wb_data);
         chk("pre err", 32'h0, addr_error);
      end
   endtask

   task t_disp;
      for (int s = 0; s < 3; s++) begin
         req(oag_pkg::AM_DISP4, oag_pkg::IM_NONE, oag_pkg::opsize_t'(s), 16'h001f,
             16'h0000, 32'h0000_1000);
         chk("disp4 ea", 32'h1000 + (32'hf << s), ea);
         chk("disp4 err", 32'h0, addr_error);
         req(oag_pkg::AM_DISP12, oag_pkg::IM_NONE, oag_pkg::opsize_t'(s), 16'h0010,
             16'h0fff, 32'h0000_1000);
         chk("disp12 ea", 32'h0000_1fff, ea);
         chk("disp12 err", (s != 0) ? 32'h1 : 32'h0, addr_error);
         req(oag_pkg::AM_GBR_DISP, oag_pkg::IM_NONE, oag_pkg::opsize_t'(s), 16'h00ff,
             16'h0000, 32'h0000_0000);
         chk("gbr disp ea", 32'h4000 + (32'hff << s), ea);
      end
   endtask

   task t_index_pc;
      req(oag_pkg::AM_IND, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h0030, 16'h0000,
          32'h0000_0102);
      chk("ind ea", 32'h0000_0102, ea);
      chk("ind err", 32'h1, addr_error);
      req(oag_pkg::AM_IND, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h0030, 16'h0000,
          32'h0000_0104);
      chk("ind valid", 32'h1, ea_valid);
      chk("ind ok err", 32'h0, addr_error);
      req(oag_pkg::AM_IDX, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h0030, 16'h0000,
          32'h8000_0001);
      chk("idx ea", 32'h0000_0004, ea);
      req(oag_pkg::AM_GBR_IDX, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h0030, 16'h0000,
          32'h0000_0000);
      chk("gbr idx ea", 32'h8000_4003, ea);
      chk("gbr idx err", 32'h1, addr_error);
      req(oag_pkg::AM_PC_DISP, oag_pkg::IM_NONE, oag_pkg::SZ_WORD, 16'h0381, 16'h0000,
          32'h0000_0000);
      chk("pc word ea", 32'h0000_2104, ea);
      chk("dest", 32'h3, dest_gpr);
      req(oag_pkg::AM_PC_DISP, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h0381, 16'h0000,
          32'h0000_0000);
      chk("pc long ea", 32'h0000_2204, ea);
      req(oag_pkg::AM_BR8, oag_pkg::IM_NONE, oag_pkg::SZ_WORD, 16'h0080, 16'h0000,
          32'h0000_0000);
      chk("br8 ea", 32'h0000_1f02, ea);
      req(oag_pkg::AM_BR12, oag_pkg::IM_NONE, oag_pkg::SZ_WORD, 16'h0800, 16'h0000,
          32'h0000_0000);
      chk("br12 ea", 32'h0000_1002, ea);
      req(oag_pkg::AM_BR_REG, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h0030, 16'h0000,
          32'h0000_0003);
      chk("br reg ea", 32'h0000_2005, ea);
      chk("br reg err", 32'h0, addr_error);
   endtask

   task t_table;
      int n;
      req(oag_pkg::AM_TBR_DBL, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h00ff, 16'h0000,
          32'h0000_0000);
      chk("tbl req", 32'h1, tbl_rd_req);
      chk("tbl addr", 32'h0010_03fc, tbl_rd_addr);
      chk("tbl busy", 32'h1, busy);
      req(oag_pkg::AM_POSTINC, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h0050, 16'h0000,
          32'h0000_0100);
      chk("refused wb", 32'h0, wb_valid);
      chk("refused ea_valid", 32'h0, ea_valid);
      n = 0;
      while (ea_valid !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("tbl ea_valid", 32'h1, ea_valid);
      chk("tbl ea", 32'h0010_03fc ^ 32'ha5a5_0f0f, ea);
   endtask

   task t_imm;
      req(oag_pkg::AM_NONE, oag_pkg::IM_IMM20, oag_pkg::SZ_LONG, 16'h0080, 16'h1234,
          32'h0000_0000);
      chk("imm valid", 32'h1, imm_valid);
      chk("imm20", 32'hfff8_1234, imm_out);
      req(oag_pkg::AM_NONE, oag_pkg::IM_IMM20S, oag_pkg::SZ_LONG, 16'h0080, 16'h1234,
          32'h0000_0000);
      chk("imm20s", 32'hf812_3400, imm_out);
      req(oag_pkg::AM_NONE, oag_pkg::IM_ZX8, oag_pkg::SZ_LONG, 16'h0080, 16'h0000,
          32'h0000_0000);
      chk("zx8", 32'h0000_0080, imm_out);
      req(oag_pkg::AM_NONE, oag_pkg::IM_SX8, oag_pkg::SZ_LONG, 16'h0080, 16'h0000,
          32'h0000_0000);
      chk("sx8", 32'hffff_ff80, imm_out);
      req(oag_pkg::AM_NONE, oag_pkg::IM_TRAP, oag_pkg::SZ_LONG, 16'h00ff, 16'h0000,
          32'h0000_0000);
      chk("trap", 32'h0000_03fc, imm_out);
      req(oag_pkg::AM_NONE, oag_pkg::IM_BIT3, oag_pkg::SZ_BYTE, 16'h00fd, 16'h0000,
          32'h0000_0000);
      chk("bit imm", 32'h0000_0005, imm_out);
      chk("mac src off", 32'h0, src2_is_dest);
      @(posedge clk);
      mac_op <= 1'b1;
      req(oag_pkg::AM_NONE, oag_pkg::IM_NONE, oag_pkg::SZ_LONG, 16'h5a6b, 16'h0000,
          32'h0000_0000);
      chk("dest", 32'ha, dest_gpr);
      chk("src", 32'h6, src_gpr);
      chk("bit no", 32'h3, bit_no);
      chk("bit op", 32'h1, bit_op_sel);
      chk("mac src", 32'h1, src2_is_dest);
   endtask

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      req_valid = 1'b0;
      mac_op = 1'b0;
      amode = oag_pkg::AM_NONE;
      imode = oag_pkg::IM_NONE;
      opsize = oag_pkg::SZ_BYTE;
      insn_hw0 = 16'h0000;
      insn_hw1 = 16'h0000;
      base_val = 32'h0000_0000;
      gpr_zero = 32'h8000_0003;
      global_base_reg = 32'h0000_4000;
      table_base_reg = 32'h0010_0000;
      pc_val = 32'h0000_2002;
      wait_cycles = 4'h3;
      err_total = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("reset busy", 32'h0, busy);
      chk("reset ea_valid", 32'h0, ea_valid);
      t_incdec();
      t_disp();
      t_index_pc();
      t_table();
      t_imm();
      stop_test();
   end

   initial begin
      #200000;
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
